// ### rtl/ccd_cfg.svh
// Timing counts and encodings for the card detect block.
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

`define CCD_CLK_HZ        10000000
`define CCD_OSC_HZ        16000
`define CCD_OSC_DIV       (`CCD_CLK_HZ / `CCD_OSC_HZ)
`define CCD_DEBOUNCE_MS   50
`define CCD_DEBOUNCE_TICKS ((`CCD_DEBOUNCE_MS * `CCD_OSC_HZ + 999) / 1000)
`define CCD_TICK_W        10
`define CCD_DIV_W         10
`define CCD_FM_SOCKETS    4

// Contact codes per pin: ground, open, tied to a partner contact.
`define CCD_PIN_GND       2'h0
`define CCD_PIN_OPEN      2'h1
`define CCD_PIN_TIED      2'h2

`endif

// ### rtl/ccd_pkg.sv
// Types shared by the card detect block.
package ccd_pkg;

	typedef enum logic [1:0] {
		CCD_SOCK_EMPTY = 2'h0,
		CCD_SOCK_CARD  = 2'h1,
		CCD_SOCK_POWER = 2'h2
	} ccd_sock_e;

	typedef enum logic [2:0] {
		CCD_TYPE_NONE    = 3'h0,
		CCD_TYPE_PC16    = 3'h1,
		CCD_TYPE_CARDBUS = 3'h2,
		CCD_TYPE_USB     = 3'h3
	} ccd_type_e;

	typedef struct packed {
		logic card_detect_one;
		logic card_detect_two;
		logic voltage_sense_one;
		logic voltage_sense_two;
		logic [1:0] tie_cd1;
		logic [1:0] tie_cd2;
	} ccd_contacts_s;

	typedef struct packed {
		ccd_type_e card_type;
		logic      volt_5v;
		logic      volt_3v;
		logic      volt_xv;
		logic      volt_yv;
		logic      low_volt_card_flag;
		logic      extra_volt_card_flag;
	} ccd_status_s;

endpackage

// ### rtl/ccd_debounce.sv
// Insertion filter for one active-low detect contact.
`timescale 1ns/1ps
`include "ccd_cfg.svh"
module ccd_debounce #(
	// Insertion interval in slow ticks; must fit the counter width.
	parameter int DEB_TICKS = `CCD_DEBOUNCE_TICKS
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic tick_i,
	input  wire logic raw_n_i,
	output logic      present_o
);
	import ccd_pkg::*;

	typedef struct packed {
		logic [`CCD_TICK_W-1:0] cnt;
		logic                   present;
	} ccd_deb_s;

	ccd_deb_s st_q;
	ccd_deb_s st_d;

	always_comb begin
		st_d = st_q;
		if (raw_n_i) begin
			// Removal is immediate and restarts the interval.
			st_d.cnt = '0;
			st_d.present = 1'b0;
		end else if (!st_q.present && tick_i) begin
			if (st_q.cnt == `CCD_TICK_W'(DEB_TICKS - 1)) begin
				st_d.present = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + `CCD_TICK_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign present_o = st_q.present;
endmodule // ccd_debounce

// ### rtl/ccd_sock_fsm.sv
// Three-state detect and power sequence for one socket.
`timescale 1ns/1ps
module ccd_sock_fsm (
	input  wire logic     ref_clk_i,
	input  wire logic     rst_n_i,
	input  wire logic     present_i,
	input  wire logic     power_req_i,
	output ccd_pkg::ccd_sock_e state_o
);
	import ccd_pkg::*;

	typedef struct packed {
		ccd_sock_e state;
	} ccd_fsm_s;

	ccd_fsm_s st_q;
	ccd_fsm_s st_d;

	always_comb begin
		st_d = st_q;
		case (st_q.state)
			CCD_SOCK_EMPTY: begin
				if (present_i) st_d.state = CCD_SOCK_CARD;
			end
			CCD_SOCK_CARD: begin
				if (!present_i) st_d.state = CCD_SOCK_EMPTY;
				else if (power_req_i) st_d.state = CCD_SOCK_POWER;
			end
			CCD_SOCK_POWER: begin
				if (!present_i) st_d.state = CCD_SOCK_EMPTY;
				else if (!power_req_i) st_d.state = CCD_SOCK_CARD;
			end
			default: st_d.state = CCD_SOCK_EMPTY;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q.state <= CCD_SOCK_EMPTY;
		end else begin
			st_q <= st_d;
		end
	end

	assign state_o = st_q.state;
endmodule // ccd_sock_fsm

// ### rtl/ccd_top.sv
// Socket card detection, insertion filtering and socket power sequencing.
// Contract
// - 1.8V CardBus, select zero sets low flag.
// - 1.8V CardBus, select one sets extra flag.
// - Insertion into cold socket starts interrogation.
// - Classify from four detect and sense contacts.
// - Recognise USB custom cards.
// - Other custom cards report empty socket.
// - Flash detect low means socket occupied.
// - Flash insertion accepted after 50 ms stable.
// - Flash removal reported immediately.
// - Flash decisions use filtered detect only.
// - Flash socket has three power states.
// - Smart card detect low means occupied.
// - Smart card insertion needs 50 ms stable.
// - Smart card removal registered at once.
// - Smart card decisions use filtered detect.
// - Smart card socket has three states.
// - Slow 16 kHz tick drives interrogation.
`timescale 1ns/1ps
`include "ccd_cfg.svh"
module ccd_top #(
	// Silicon keeps the default; a bench may shorten the interval.
	parameter int DEB_TICKS = `CCD_DEBOUNCE_TICKS
) (
	// Clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	// PC Card socket contacts
	input  wire ccd_pkg::ccd_contacts_s contacts_i,
	input  wire logic                 supply_switch_select_i,
	// Flash media and smart card detect contacts
	input  wire logic                 sd_socket_present_n_i,
	input  wire logic                 stick_socket_present_n_i,
	input  wire logic                 media_socket_present_n_i,
	input  wire logic                 picture_socket_present_n_i,
	input  wire logic                 smartcard_present_n_i,
	// Socket power requests
	input  wire logic [3:0]           fm_power_req_i,
	input  wire logic                 sc_power_req_i,
	// Status
	output ccd_pkg::ccd_status_s      pc_status_o,
	output logic                      pc_interrogating_o,
	output logic [3:0]                fm_present_o,
	output logic [3:0]                fm_power_o,
	output logic                      sc_present_o,
	output logic                      sc_power_o
);
	import ccd_pkg::*;

	typedef struct packed {
		logic [`CCD_DIV_W-1:0] div;
		logic                  tick;
		logic                  inserted;
		logic                  interrogating;
		ccd_status_s           status;
		logic [3:0]            fm_present;
		logic [3:0]            fm_power;
		logic                  sc_present;
		logic                  sc_power;
	} ccd_top_s;

	ccd_top_s      st_q;
	ccd_top_s      st_d;
	ccd_status_s   decode;
	logic [4:0]    raw_n;
	logic [4:0]    filt;
	logic [4:0]    pwr_req;
	ccd_sock_e     sock_st [5];
	logic          card_in;

	assign raw_n = {smartcard_present_n_i, picture_socket_present_n_i,
		media_socket_present_n_i, stick_socket_present_n_i,
		sd_socket_present_n_i};
	assign pwr_req = {sc_power_req_i, fm_power_req_i};

	// Card is in when either detect contact is grounded.
	assign card_in = !contacts_i.card_detect_one ||
		!contacts_i.card_detect_two;

	always_comb begin
		logic g1;
		logic g2;
		logic s1o;
		logic s2o;
		g1 = 1'b0;
		g2 = 1'b0;
		s1o = 1'b0;
		s2o = 1'b0;
		decode = '0;
		decode.card_type = CCD_TYPE_NONE;
		g1 = (contacts_i.tie_cd1 == `CCD_PIN_GND);
		g2 = (contacts_i.tie_cd2 == `CCD_PIN_GND);
		s1o = contacts_i.voltage_sense_one;
		s2o = contacts_i.voltage_sense_two;
		if (g1 && g2) begin
			// 16-bit cards: both detects grounded.
			decode.card_type = CCD_TYPE_PC16;
			decode.volt_5v = s1o;
			decode.volt_3v = !s1o;
			decode.volt_xv = !s2o;
		end else if (contacts_i.tie_cd1 == `CCD_PIN_TIED && g2) begin
			decode.card_type = CCD_TYPE_CARDBUS;
			decode.volt_3v = 1'b1;
			decode.volt_xv = !s2o;
		end else if (g1 && contacts_i.tie_cd2 == `CCD_PIN_TIED) begin
			decode.card_type = CCD_TYPE_CARDBUS;
			decode.volt_3v = s1o;
			decode.volt_yv = !s1o;
			decode.low_volt_card_flag = s2o && !supply_switch_select_i;
			decode.extra_volt_card_flag = s2o && supply_switch_select_i;
		end else if (contacts_i.tie_cd1 == `CCD_PIN_TIED &&
			contacts_i.tie_cd2 == `CCD_PIN_TIED) begin
			if (!s1o && !s2o) decode.card_type = CCD_TYPE_USB;
		end
		if (decode.card_type == CCD_TYPE_NONE || !card_in) decode = '0;
	end

	for (genvar i = 0; i < 5; i++) begin : g_sock
		ccd_debounce #(.DEB_TICKS(DEB_TICKS)) u_deb (
			.ref_clk_i (ref_clk_i),
			.rst_n_i   (rst_n_i),
			.tick_i    (st_q.tick),
			.raw_n_i   (raw_n[i]),
			.present_o (filt[i])
		);
		ccd_sock_fsm u_fsm (
			.ref_clk_i   (ref_clk_i),
			.rst_n_i     (rst_n_i),
			.present_i   (filt[i]),
			.power_req_i (pwr_req[i]),
			.state_o     (sock_st[i])
		);
	end

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.div == `CCD_DIV_W'(`CCD_OSC_DIV - 1)) begin
			st_d.div = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.div = st_q.div + `CCD_DIV_W'(1);
		end
		st_d.inserted = card_in;
		if (card_in && !st_q.inserted) begin
			st_d.interrogating = 1'b1;
		end else if (st_q.interrogating && st_q.tick) begin
			st_d.interrogating = 1'b0;
			st_d.status = decode;
		end
		if (!card_in) begin
			st_d.interrogating = 1'b0;
			st_d.status = '0;
		end
		for (int i = 0; i < 4; i++) begin
			st_d.fm_present[i] = filt[i];
			st_d.fm_power[i] = (sock_st[i] == CCD_SOCK_POWER);
		end
		st_d.sc_present = filt[4];
		st_d.sc_power = (sock_st[4] == CCD_SOCK_POWER);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Status is latched only after interrogation so a half-seated card
	// cannot flash a wrong type at software.
	assign pc_status_o = st_q.status;
	assign pc_interrogating_o = st_q.interrogating;
	assign fm_present_o = st_q.fm_present;
	assign fm_power_o = st_q.fm_power;
	assign sc_present_o = st_q.sc_present;
	assign sc_power_o = st_q.sc_power;
endmodule // ccd_top

// ### bench/ccd_card_model.sv
// Removable card and socket contact model.
`timescale 1ns/1ps
module ccd_card_model (
	// Card choice from the bench
	input	wire logic [2:0]	kind_i,
	input	wire logic [3:0]	fm_ins_i,
	input	wire logic	sc_ins_i,
	// Socket contacts
	output	ccd_pkg::ccd_contacts_s	contacts_o,
	output	logic [3:0]	fm_n_o,
	output	logic	sc_n_o
);
	import ccd_pkg::*;
	// Empty sockets read high through their pull-ups.
	assign fm_n_o = ~fm_ins_i;
	assign sc_n_o = ~sc_ins_i;
	always_comb begin
		case (kind_i)
			3'h1: contacts_o = 8'h30;
			3'h2: contacts_o = 8'h0A;
			3'h3: contacts_o = 8'h3A;
			3'h4: contacts_o = 8'h12;
			default: contacts_o = 8'hF5;
		endcase
	end
endmodule // ccd_card_model

// ### bench/ccd_top_assertions.sv
// Port assertions for the card detect block.
`timescale 1ns/1ps
`include "ccd_cfg.svh"
module ccd_top_assertions #(
	parameter int DEB_TICKS = `CCD_DEBOUNCE_TICKS
) (
	input	wire logic	ref_clk_i,
	input	wire logic	rst_n_i,
	input	wire logic	sd_socket_present_n_i,
	input	wire logic	stick_socket_present_n_i,
	input	wire logic	media_socket_present_n_i,
	input	wire logic	picture_socket_present_n_i,
	input	wire logic	smartcard_present_n_i,
	input	wire logic	sc_power_req_i,
	input	wire ccd_pkg::ccd_status_s	pc_status_o,
	input	wire logic [3:0]	fm_present_o,
	input	wire logic [3:0]	fm_power_o,
	input	wire logic	sc_present_o,
	input	wire logic	sc_power_o
);
	import ccd_pkg::*;
	// Earliest and latest low-run lengths at which the filter may open.
	localparam int LO_MIN = (DEB_TICKS - 1) * `CCD_OSC_DIV + 2;
	localparam int LO_MAX = DEB_TICKS * `CCD_OSC_DIV + 1;
	logic [3:0]	raw;
	int	lo_q;
	assign raw = {picture_socket_present_n_i, media_socket_present_n_i,
		stick_socket_present_n_i, sd_socket_present_n_i};
	// Counts cycles of an unbroken low on the smart card contact.
	always_ff @(posedge ref_clk_i)
		lo_q <= (smartcard_present_n_i || !rst_n_i) ? '0 : lo_q + 1;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_fm_need_low: assert property (
		(fm_present_o & $past(raw, 3)) == 4'h0) else $error("fm early");
	a_sc_need_low: assert property (
		sc_present_o |-> !$past(smartcard_present_n_i, 3)) else $error("sc");
	a_sc_not_early: assert property (
		$rose(sc_present_o) |-> lo_q >= LO_MIN) else $error("sc soon");
	a_sc_not_late: assert property (
		lo_q == LO_MAX |-> sc_present_o) else $error("sc late");
	a_fm_pwr_pres: assert property (
		(fm_power_o & ~$past(fm_present_o)) == 4'h0) else $error("fm pwr");
	a_sc_pwr_pres: assert property (
		sc_power_o |-> $past(sc_present_o)) else $error("sc pwr");
	a_sc_pwr_on: assert property (
		$rose(sc_present_o) && sc_power_req_i |-> ##[1:3] sc_power_o)
		else $error("sc no pwr");
	a_pc_flag_excl: assert property (
		!(pc_status_o.low_volt_card_flag && pc_status_o.extra_volt_card_flag))
		else $error("flags");
	a_pc_flag_kind: assert property (
		pc_status_o[1:0] != 2'h0 |-> pc_status_o.card_type == CCD_TYPE_CARDBUS)
		else $error("flag type");
	a_pc_empty_clr: assert property (
		pc_status_o.card_type == CCD_TYPE_NONE |-> pc_status_o[5:0] == 6'h00)
		else $error("empty");
	cover property ($rose(sc_power_o));
	cover property ($rose(fm_present_o[3]));
	cover property (pc_status_o.card_type == CCD_TYPE_USB);
endmodule // ccd_top_assertions
bind ccd_top ccd_top_assertions #(.DEB_TICKS(DEB_TICKS))
	ccd_top_assertions_i (.*);

// ### bench/tb.sv
// Self-checking bench for the card detect block.
`timescale 1ns/1ps
module tb;
	import ccd_pkg::*;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic	sel = 1'b0;
	logic [2:0]	kind = 3'h0;
	logic [3:0]	fm_ins = 4'h0;
	logic [3:0]	fm_req = 4'h0;
	logic	sc_ins = 1'b0;
	logic	sc_req = 1'b0;
	ccd_contacts_s	cts;
	ccd_status_s	st;
	logic [3:0]	fm_n, fm_pres, fm_pwr;
	logic	sc_n, sc_pres, sc_pwr, pc_int;
	logic [4:0]	pres, pwr, pc_sum;
	int	n_fail = 0;
	int	n_checks = 0;
	// A short insertion interval keeps the run brief; the wait limits are cycle counts sized for it.
	localparam int DEB = 16;
	assign pres = {fm_pres, sc_pres};
	assign pwr = {fm_pwr, sc_pwr};
	assign pc_sum = {st.card_type, st[1:0]};
	always #50 clk = ~clk;
	ccd_card_model ccd_card_model_i (.kind_i(kind), .fm_ins_i(fm_ins),
		.sc_ins_i(sc_ins), .contacts_o(cts), .fm_n_o(fm_n), .sc_n_o(sc_n));
	ccd_top #(.DEB_TICKS(DEB)) ccd_top_i (.ref_clk_i(clk), .rst_n_i(rst_n),
		.contacts_i(cts),
		.supply_switch_select_i(sel), .sd_socket_present_n_i(fm_n[0]),
		.stick_socket_present_n_i(fm_n[1]), .media_socket_present_n_i(fm_n[2]),
		.picture_socket_present_n_i(fm_n[3]), .smartcard_present_n_i(sc_n),
		.fm_power_req_i(fm_req), .sc_power_req_i(sc_req), .pc_status_o(st),
		.pc_interrogating_o(pc_int), .fm_present_o(fm_pres),
		.fm_power_o(fm_pwr), .sc_present_o(sc_pres), .sc_power_o(sc_pwr));
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Every wait is bounded so a stuck filter cannot hang the run.
	task automatic wait_pres(input logic [4:0] want, input int lim);
		int i;
		for (i = 0; i < lim && pres !== want; i++)
			cyc(1);
		if (i == lim) begin
			n_fail++;
			$display("unexpected at %0t: wait ran out", $time);
			end_of_test();
		end
	endtask
	task automatic t_pc();
		logic [4:0] exp_t [6] = '{5'h00, 5'h04, 5'h0C, 5'h00, 5'h0A, 5'h09};
		for (int k = 0; k < 6; k++) begin
			kind = 3'h0;
			cyc(1300);
			kind = (k == 5) ? 3'h4 : 3'(k);
			sel = (k == 5);
			cyc(1);
			chk({4'h0, pc_int}, (k == 0) ? 5'h00 : 5'h01);
			cyc(1300);
			chk({4'h0, pc_int}, 5'h00);
			chk(pc_sum, exp_t[k]);
		end
		$display("test pc_detect done");
	endtask
	// One interval serves all sockets, since they share the slow tick; each socket keeps its own count.
	task automatic t_deb();
		fm_req = 4'hF;
		sc_req = 1'b1;
		fm_ins = 4'hF;
		sc_ins = 1'b1;
		cyc(5000);
		chk(pres, 5'h00);
		chk(pwr, 5'h00);
		sc_ins = 1'b0;
		cyc(2);
		sc_ins = 1'b1;
		wait_pres(5'h1E, 11000);
		cyc(3);
		chk(pwr, 5'h1E);
		wait_pres(5'h1F, 11000);
		cyc(700);
		chk(pwr, 5'h1F);
		fm_ins = 4'h5;
		sc_ins = 1'b0;
		cyc(4);
		chk(pres, 5'h0A);
		chk(pwr, 5'h0A);
		$display("test debounce done");
	endtask
	initial begin
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		chk(pres, 5'h00);
		t_pc();
		t_deb();
		end_of_test();
	end
endmodule // tb
